// file: common/ccw_pkg.sv
// Shared constants and types of the comparator control and wake-up block
package ccw_pkg;
   // Width of the digitised analog levels presented at the comparator inputs
   localparam int LVL_W = 8;

   // Register word indexes; the byte address is four times the index
   localparam logic [5:0] IDX_STATUS = 6'h03;
   localparam logic [5:0] IDX_CTRL1_A = 6'h07;
   localparam logic [5:0] IDX_CTRL1_B = 6'h08;
   localparam logic [5:0] IDX_CTRL2 = 6'h0b;
   localparam logic [5:0] IDX_DIR_B = 6'h10;
   localparam logic [5:0] IDX_DIR_C = 6'h11;
   localparam logic [5:0] IDX_DIR_GP = 6'h12;
   localparam logic [5:0] IDX_EVT = 6'h13;
   localparam logic [5:0] IDX_MASK = 6'h14;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'hff;
   localparam logic [5:0] DIR_RESET = 6'h3f;
   localparam logic [2:0] EVT_RESET = 3'h0;
   localparam logic [1:0] ANALOG_RESET = 2'h3;

   // Field positions
   localparam int STATUS_WAKE_BIT = 6;
   localparam int CTRL_RESULT_BIT = 7;
   localparam int DIR_W = 6;
   localparam int EVT_W = 3;
   localparam int EVT_CMP1 = 0;
   localparam int EVT_CMP2 = 1;
   localparam int EVT_WAKE = 2;
   localparam int CMP1_PIN = 2;
   localparam int CMP2_PIN = 4;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic result;
      logic pin_drive_enable;
      logic polarity;
      logic select_b;
      logic enable;
      logic negative_select;
      logic positive_select_a;
      logic wake_enable_n;
   } ccw_ctrl_t;

   // Analog levels, digitised, as seen at the comparator pins
   typedef struct packed {
      logic [LVL_W-1:0] cmp1_positive_pin;
      logic [LVL_W-1:0] cmp1_negative_pin;
      logic [LVL_W-1:0] cmp2_positive_pin;
      logic [LVL_W-1:0] cmp2_negative_pin;
      logic [LVL_W-1:0] internal_ref_voltage;
   } ccw_analog_t;
endpackage : ccw_pkg

// file: hw/ccw_top.sv
// Comparator control registers, input routing, pin override and wake flag
`timescale 1ns/1ns

module ccw_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic wake_reset_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Core state
   input wire logic sleep_i,
   input wire logic timer_clock_source_select_i,
   // Analog side
   input wire ccw_pkg::ccw_analog_t analog_i,
   // Pins and events
   output logic [ccw_pkg::DIR_W-1:0] port_b_dir_o,
   output logic [ccw_pkg::DIR_W-1:0] port_c_dir_o,
   output logic [ccw_pkg::DIR_W-1:0] gp_dir_o,
   output logic port_b_pin2_o,
   output logic port_c_pin4_o,
   output logic [1:0] pins_analog_o,
   output logic wake_o,
   output logic irq_o
);
   import ccw_pkg::*;

   function automatic logic compare(input logic [LVL_W-1:0] pos, input logic [LVL_W-1:0] neg);
      compare = !(pos < neg);
   endfunction : compare

   function automatic logic polar(input logic raw, input logic pol);
      polar = pol ? raw : !raw;
   endfunction : polar

   // Three-stage synchroniser on the analog levels
   ccw_analog_t s1_q, s2_q, s3_q, lvl_q, lvl_d;

   always_comb begin
      lvl_d = lvl_q;
      // Only accept a level once two stages agree, so a code caught mid-change never counts
      if (s2_q == s3_q) begin
         lvl_d = s3_q;
      end
   end

   always_ff @(posedge clk_i) begin
      s1_q <= analog_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
   end

   // Bus decode
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic acc, wr, rd;
   logic [5:0] idx;
   assign idx = wb_adr_i[7:2];
   assign acc = wb_cyc_i && wb_stb_i && !ack_q;
   // Writes land at the edge where the master samples ack, while it still holds the data
   assign wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
   assign rd = acc && !wb_we_i;

   // Comparator inputs and results
   ccw_ctrl_t ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
   logic [LVL_W-1:0] c2_pos, c2_neg;
   logic c1_raw, c2_raw, c1_new, c2_new;

   always_comb begin
      if (ctrl2_q.positive_select_a) begin
         c2_pos = lvl_q.cmp2_positive_pin;
      end else if (ctrl2_q.select_b) begin
         c2_pos = lvl_q.cmp1_positive_pin;
      end else begin
         c2_pos = lvl_q.cmp2_negative_pin;
      end
      c2_neg = ctrl2_q.negative_select ? lvl_q.cmp2_negative_pin : lvl_q.internal_ref_voltage;
      c1_raw = compare(ctrl1_q.positive_select_a ? lvl_q.cmp1_positive_pin : lvl_q.cmp1_negative_pin,
                       ctrl1_q.negative_select ? lvl_q.cmp1_negative_pin : lvl_q.internal_ref_voltage);
      c2_raw = compare(c2_pos, c2_neg);
      // Sleep is not looked at: an enabled comparator keeps running and drawing current
      c1_new = ctrl1_q.enable ? polar(c1_raw, ctrl1_q.polarity) : 1'b0;
      c2_new = ctrl2_q.enable ? polar(c2_raw, ctrl2_q.polarity) : 1'b0;
   end

   always_comb begin
      ctrl1_d = ctrl1_q;
      ctrl2_d = ctrl2_q;
      if (wr && (idx == IDX_CTRL1_A || idx == IDX_CTRL1_B)) begin
         ctrl1_d = ccw_ctrl_t'(wb_dat_i[7:0]);
      end
      if (wr && idx == IDX_CTRL2) begin
         ctrl2_d = ccw_ctrl_t'(wb_dat_i[7:0]);
      end
      ctrl1_d.result = c1_new;
      ctrl2_d.result = c2_new;
      // Other resets leave the control registers untouched
      if (rst_i && por_i) begin
         ctrl1_d = ccw_ctrl_t'(CTRL_RESET);
         ctrl2_d = ccw_ctrl_t'(CTRL_RESET);
      end
   end

   always_ff @(posedge clk_i) begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
   end

   // Wake flag with latch-on-read reference
   logic flag_q, flag_d, armed_q, armed_d, lat1_q, lat1_d, lat2_q, lat2_d, set_wake;

   always_comb begin
      lat1_d = lat1_q;
      lat2_d = lat2_q;
      armed_d = armed_q;
      if (rd && (idx == IDX_CTRL1_A || idx == IDX_CTRL1_B || idx == IDX_CTRL2)) begin
         lat1_d = ctrl1_q.result;
         lat2_d = ctrl2_q.result;
         armed_d = 1'b1;
      end
      set_wake = sleep_i && armed_q && ((!ctrl1_q.wake_enable_n && ctrl1_q.result != lat1_q) ||
                 (!ctrl2_q.wake_enable_n && ctrl2_q.result != lat2_q));
      flag_d = flag_q;
      if (wr && idx == IDX_STATUS) begin
         flag_d = wb_dat_i[STATUS_WAKE_BIT];
      end
      // A change in the clearing cycle is kept
      flag_d = flag_d || set_wake;
      if (rst_i) begin
         flag_d = wake_reset_i ? flag_q : 1'b0;
         armed_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      flag_q <= flag_d;
      armed_q <= armed_d;
      lat1_q <= lat1_d;
      lat2_q <= lat2_d;
   end

   // Direction registers, event status and mask
   logic [DIR_W-1:0] dir_b_q, dir_b_d, dir_c_q, dir_c_d, dir_gp_q, dir_gp_d;
   logic [EVT_W-1:0] evt_q, evt_d, mask_q, mask_d, evt_set;

   always_comb begin
      dir_b_d = dir_b_q;
      dir_c_d = dir_c_q;
      dir_gp_d = dir_gp_q;
      mask_d = mask_q;
      if (wr && idx == IDX_DIR_B) begin
         dir_b_d = wb_dat_i[DIR_W-1:0];
      end
      if (wr && idx == IDX_DIR_C) begin
         dir_c_d = wb_dat_i[DIR_W-1:0];
      end
      if (wr && idx == IDX_DIR_GP) begin
         dir_gp_d = wb_dat_i[DIR_W-1:0];
      end
      if (wr && idx == IDX_MASK) begin
         mask_d = wb_dat_i[EVT_W-1:0];
      end
      evt_set = '0;
      evt_set[EVT_CMP1] = c1_new != ctrl1_q.result;
      evt_set[EVT_CMP2] = c2_new != ctrl2_q.result;
      evt_set[EVT_WAKE] = set_wake && !flag_q;
      // Read clears, but an event in the same cycle survives
      evt_d = ((rd && idx == IDX_EVT) ? EVT_RESET : evt_q) | evt_set;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_b_q <= DIR_RESET;
         dir_c_q <= DIR_RESET;
         dir_gp_q <= DIR_RESET;
         evt_q <= EVT_RESET;
         mask_q <= EVT_RESET;
      end else begin
         dir_b_q <= dir_b_d;
         dir_c_q <= dir_c_d;
         dir_gp_q <= dir_gp_d;
         evt_q <= evt_d;
         mask_q <= mask_d;
      end
   end

   // Registered pin view and bus answer
   logic [DIR_W-1:0] pb_d, pc_d;

   always_comb begin
      pb_d = dir_b_q;
      pc_d = dir_c_q;
      if (ctrl1_q.enable && ctrl1_q.pin_drive_enable) begin
         pb_d[CMP1_PIN] = 1'b0;
      end
      if (ctrl2_q.enable && ctrl2_q.pin_drive_enable) begin
         pc_d[CMP2_PIN] = 1'b0;
      end else if (timer_clock_source_select_i) begin
         pc_d[CMP2_PIN] = 1'b1;
      end
      ack_d = acc;
      rdat_d = '0;
      if (acc && !wb_we_i) begin
         case (idx)
            IDX_STATUS: rdat_d[STATUS_WAKE_BIT] = flag_q;
            IDX_CTRL1_A, IDX_CTRL1_B: rdat_d[7:0] = ctrl1_q;
            IDX_CTRL2: rdat_d[7:0] = ctrl2_q;
            IDX_EVT: rdat_d[EVT_W-1:0] = evt_q;
            IDX_MASK: rdat_d[EVT_W-1:0] = mask_q;
            // Direction registers are write-only and read zero
            default: rdat_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= '0;
         port_b_dir_o <= DIR_RESET;
         port_c_dir_o <= DIR_RESET;
         gp_dir_o <= DIR_RESET;
         port_b_pin2_o <= 1'b0;
         port_c_pin4_o <= 1'b0;
         pins_analog_o <= ANALOG_RESET;
         wake_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         port_b_dir_o <= pb_d;
         port_c_dir_o <= pc_d;
         gp_dir_o <= dir_gp_q;
         port_b_pin2_o <= ctrl1_q.result;
         port_c_pin4_o <= ctrl2_q.result;
         pins_analog_o <= {ctrl2_q.enable, ctrl1_q.enable};
         wake_o <= flag_q;
         irq_o <= |(evt_q & mask_q);
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // Checks
   logic wr_c1, wr_c2;
   assign wr_c1 = wr && (idx == IDX_CTRL1_A || idx == IDX_CTRL1_B);
   assign wr_c2 = wr && idx == IDX_CTRL2;

   property p_c1_result;
      @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctrl1_q.enable && !wr_c1) |=> ctrl1_q.result == $past(polar(c1_raw, ctrl1_q.polarity));
   endproperty
   a_c1_result: assert property (p_c1_result) else $error("cmp1 result wrong");

   property p_c2_result;
      @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctrl2_q.enable && !wr_c2) |=> ctrl2_q.result == ($past(ctrl2_q.polarity) ? $past(c2_raw) : !$past(c2_raw));
   endproperty
   a_c2_result: assert property (p_c2_result) else $error("cmp2 polarity wrong");

   property p_result_ro;
      @(posedge clk_i) disable iff (rst_i)
      (wr_c2 && !ctrl2_q.enable && !ctrl2_q.result) |=> !ctrl2_q.result;
   endproperty
   a_result_ro: assert property (p_result_ro) else $error("result bit written");

   property p_wake_cause;
      @(posedge clk_i) disable iff (rst_i)
      ($rose(flag_q) && !$past(wr && idx == IDX_STATUS)) |-> $past(sleep_i && armed_q);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake flag without cause");

   property p_wake_clear;
      @(posedge clk_i) disable iff (rst_i)
      (wr && idx == IDX_STATUS && !wb_dat_i[STATUS_WAKE_BIT] && !set_wake) |=> !flag_q;
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake flag not cleared");

   property p_por_value;
      @(posedge clk_i) disable iff (rst_i)
      ($fell(rst_i) && $past(por_i)) |-> ctrl2_q[6:0] == CTRL_RESET[6:0];
   endproperty
   a_por_value: assert property (p_por_value) else $error("power-on value missing");

   property p_disabled_dir;
      @(posedge clk_i) disable iff (rst_i)
      (!rst_i && !ctrl2_q.enable && !timer_clock_source_select_i) |=> port_c_dir_o[CMP2_PIN] == $past(dir_c_q[CMP2_PIN]);
   endproperty
   a_disabled_dir: assert property (p_disabled_dir) else $error("disabled comparator steers pin");

   property p_pin_drive;
      @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctrl2_q.enable && ctrl2_q.pin_drive_enable) |=>
         !port_c_dir_o[CMP2_PIN] && port_c_pin4_o == $past(ctrl2_q.result);
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("comparator pin not driven");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
      (!rst_i && |(evt_q & mask_q)) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   c_wake: cover property (@(posedge clk_i) disable iff (rst_i) $rose(flag_q));
   c_drive: cover property (@(posedge clk_i) disable iff (rst_i) ctrl2_q.enable && ctrl2_q.pin_drive_enable);
   c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule : ccw_top

// file: tb/test_ccw_top.sv
// Randomised self-checking bench for the comparator control and wake-up block
`timescale 1ns/1ns
module test_ccw_top;
   import ccw_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic por_i = 1'b1;
   logic wake_reset_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, sleep_i = 1'b0, tcs = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, pb_pin, pc_pin, wake_o, irq_o, e;
   logic [5:0] pb_dir, pc_dir, gp_dir, d;
   logic [1:0] pins_an;
   logic [7:0] c;
   ccw_analog_t analog_i = '0;
   ccw_analog_t av;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int seed = 32'h88af;

   ccw_top dut (
      .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wake_reset_i(wake_reset_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .sleep_i(sleep_i), .timer_clock_source_select_i(tcs), .analog_i(analog_i),
      .port_b_dir_o(pb_dir), .port_c_dir_o(pc_dir), .gp_dir_o(gp_dir),
      .port_b_pin2_o(pb_pin), .port_c_pin4_o(pc_pin), .pins_analog_o(pins_an),
      .wake_o(wake_o), .irq_o(irq_o)
   );

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   // Whole run needs under a thousand cycles; a hang is cut off well after that
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         test_done();
      end
   end

   task test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // One classic cycle; held until ack is sampled high, released at that edge
   task wb(input logic we, input logic [5:0] idx, input logic [7:0] wd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h0, wd};
      wb_sel_i <= 4'hf;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   task settle();
      repeat (8) @(posedge clk_i);
   endtask : settle

   task do_reset(input logic p, input logic w);
      @(posedge clk_i);
      rst_i <= 1'b1;
      por_i <= p;
      wake_reset_i <= w;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      wake_reset_i <= 1'b0;
   endtask : do_reset

   // Expected second comparator result bit; equal levels count as high
   function automatic logic exp2(input ccw_ctrl_t k, input ccw_analog_t a);
      logic [7:0] p, n;
      p = k.positive_select_a ? a.cmp2_positive_pin : (k.select_b ? a.cmp1_positive_pin : a.cmp2_negative_pin);
      n = k.negative_select ? a.cmp2_negative_pin : a.internal_ref_voltage;
      return k.enable & ((p >= n) ~^ k.polarity);
   endfunction : exp2

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      wb(1'b0, IDX_CTRL2, 8'h00);
      chk(rd & 32'h7f, 32'h7f, "ctrl2 reset");
      wb(1'b0, IDX_CTRL1_A, 8'h00);
      chk(rd & 32'h7f, 32'h7f, "ctrl1 reset");
      wb(1'b0, IDX_CTRL1_B, 8'h00);
      chk(rd & 32'h7f, 32'h7f, "ctrl1 alias reset");
      chk(pins_an, 2'b11, "analog pins after reset");
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         c = 8'($random(seed));
         c[0] = 1'b1;
         av = 40'({$random(seed), $random(seed)});
         if (i == 0) av = {5{8'h5a}};
         tcs <= i[0];
         analog_i <= av;
         wb(1'b1, IDX_CTRL2, c);
         settle();
         wb(1'b0, IDX_CTRL2, 8'h00);
         e = exp2(ccw_ctrl_t'(c), av);
         chk(rd, {24'h0, e, c[6:0]}, "ctrl2 readback");
         chk(pc_dir[4], !(c[3] && c[6]), "pin4 direction");
         if (c[3] && c[6]) chk(pc_pin, e, "pin4 value");
         chk(pins_an[1], c[3], "analog mode");
      end
      $display("test routing done");
      tcs <= 1'b0;
      d = 6'($random(seed));
      wb(1'b1, IDX_DIR_C, {2'b00, d});
      wb(1'b1, IDX_DIR_B, {2'b00, ~d});
      wb(1'b1, IDX_DIR_GP, 8'h15);
      wb(1'b1, IDX_CTRL2, 8'h37);
      settle();
      chk(pc_dir, d, "disabled leaves direction");
      chk(pb_dir, {26'h0, ~d & 6'h3b}, "port b direction");
      chk(pb_pin, av.cmp1_positive_pin >= av.cmp1_negative_pin, "cmp1 pin value");
      chk(gp_dir, 6'h15, "gp direction");
      wb(1'b0, IDX_DIR_C, 8'h00);
      chk(rd, 32'h0, "direction reads zero");
      wb(1'b1, IDX_CTRL2, 8'h7f);
      settle();
      chk(pc_dir, d & 6'h2f, "enabled drives pin");
      wb(1'b1, 6'h2a, 8'h5a);
      wb(1'b0, 6'h2a, 8'h00);
      chk(rd, 32'h0, "unmapped");
      $display("test directions done");
      av.cmp2_positive_pin = 8'h80;
      av.cmp2_negative_pin = 8'h40;
      analog_i <= av;
      wb(1'b1, IDX_CTRL2, 8'h6f);
      settle();
      wb(1'b0, IDX_EVT, 8'h00);
      wb(1'b1, IDX_MASK, 8'h02);
      analog_i.cmp2_positive_pin <= 8'h10;
      settle();
      chk(irq_o, 1'b1, "irq raised");
      wb(1'b0, IDX_EVT, 8'h00);
      chk(rd[1], 1'b1, "change event");
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0, "irq cleared by read");
      wb(1'b0, IDX_EVT, 8'h00);
      chk(rd, 32'h0, "event cleared");
      wb(1'b1, IDX_MASK, 8'h00);
      analog_i.cmp2_positive_pin <= 8'h80;
      settle();
      chk(irq_o, 1'b0, "masked irq");
      wb(1'b0, IDX_EVT, 8'h00);
      chk(rd[1], 1'b1, "masked event still recorded");
      $display("test interrupt done");
      wb(1'b1, IDX_CTRL2, 8'h6e);
      wb(1'b1, IDX_STATUS, 8'h00);
      analog_i.cmp2_positive_pin <= 8'h10;
      settle();
      wb(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 32'h0, "no wake while awake");
      wb(1'b0, IDX_CTRL2, 8'h00);
      sleep_i <= 1'b1;
      settle();
      chk(wake_o, 1'b0, "no wake without change");
      analog_i.cmp2_positive_pin <= 8'h80;
      settle();
      chk(wake_o, 1'b1, "wake on change in sleep");
      wb(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 32'h40, "wake flag");
      wb(1'b0, IDX_CTRL2, 8'h00);
      chk(rd[7], 1'b1, "result tracks in sleep");
      sleep_i <= 1'b0;
      wb(1'b1, IDX_STATUS, 8'h00);
      wb(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 32'h0, "software clear");
      wb(1'b1, IDX_STATUS, 8'h40);
      do_reset(1'b0, 1'b1);
      wb(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 32'h40, "kept by wake reset");
      wb(1'b0, IDX_CTRL2, 8'h00);
      chk(rd & 32'h7f, 32'h6e, "ctrl kept on other reset");
      do_reset(1'b0, 1'b0);
      wb(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 32'h0, "cleared by other reset");
      do_reset(1'b1, 1'b0);
      wb(1'b0, IDX_CTRL2, 8'h00);
      chk(rd & 32'h7f, 32'h7f, "power-on reload");
      $display("test wake done");
      test_done();
   end
endmodule : test_ccw_top
